// ===== design/clk_sel_pkg.sv
// Purpose: Shared constants and types of the sample clock selection block
// Assumes: Register indices times four give the Wishbone byte addresses
// Notes: Registers are at most 8 bits wide, in the low byte of a 32-bit word
package clk_sel_pkg;
   // ****************************************
   // Register indices
   // ****************************************
   localparam logic [7:0] IDX_SOFT_RESET = 8'h00;
   localparam logic [7:0] IDX_DLL_CTRL = 8'h52;
   localparam logic [7:0] IDX_CLK_SRC = 8'h53;
   localparam logic [7:0] IDX_DECIM_PH = 8'h64;
   localparam logic [7:0] IDX_CALIB = 8'h6B;
   localparam logic [7:0] IDX_PLL_OUT = 8'h6D;
   localparam logic [7:0] IDX_STATUS = 8'hD1;
   localparam int ADR_W = 10;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int DLL_EN_BIT = 0;
   localparam int DUTY_BIT = 1;
   localparam int DLL_OUTPUT_DATA_CLOCK_BIT = 2;
   localparam int PHDLY_LSB = 3;
   localparam int DLL_RST_BIT = 6;
   localparam int SRC_BIT = 0;
   localparam int DEC_PH_LSB = 0;
   localparam int DEC_EN_BIT = 3;
   localparam int CAL_TRIG_BIT = 0;
   localparam int PLL_CLK_EN_BIT = 0;
   localparam int SOFT_RST_BIT = 0;
   localparam int STAT_CAL_BIT = 0;
   localparam int STAT_SRC_BIT = 1;
   localparam int STAT_DLLRST_BIT = 2;
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] DLL_CTRL_RST = 8'h40;
   localparam logic [7:0] CLK_SRC_RST = 8'h00;
   localparam logic [7:0] DECIM_PH_RST = 8'h00;
   localparam logic [7:0] CALIB_RST = 8'h00;
   localparam logic [7:0] PLL_OUT_RST = 8'h00;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int DLL_RST_NS = 500;
   localparam int SWITCH_GAP_NS = 300;
   localparam logic [3:0] DLL_RST_CYC =
      4'((DLL_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] SWITCH_GAP_CYC =
      4'((SWITCH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   typedef enum logic [1:0] {
      SW_RUN = 2'b00,
      SW_STOP = 2'b01,
      SW_SWAP = 2'b10
   } sw_state_t;
endpackage

// ===== design/adc_sample_clock_select.sv
// Purpose: Sample clock source, delay loop and output clock phase control
// Assumes: Classic Wishbone slave, one clock, synchronous active high reset
// Notes: Clock paths are steered by level outputs to the analog clock tree
//
// Design decision made here: the Wishbone interface to the registers.
module adc_sample_clock_select (
   input wire logic REF_CLK_IN,
   input wire logic RST_IN,
   input wire logic CYC_IN,
   input wire logic STB_IN,
   input wire logic WE_IN,
   input wire logic [3:0] SEL_IN,
   input wire logic [clk_sel_pkg::ADR_W-1:0] ADR_IN,
   input wire logic [31:0] DAT_IN,
   output logic [31:0] DAT_OUT,
   output logic ACK_OUT,
   input wire logic CALIB_DONE_IN,
   output logic CORE_SRC_PLL_OUT,
   output logic CORE_CLK_GATE_OUT,
   output logic DLL_ENABLE_OUT,
   output logic DLL_RESET_OUT,
   output logic DUTY_CORR_OUT,
   output logic OUT_CLK_DLL_OUT,
   output logic OUT_CLK_DECIM_OUT,
   output logic [2:0] OUT_PHASE_OUT,
   output logic PLL_CLK_CORE_OUT,
   output logic CALIB_START_OUT
);
   import clk_sel_pkg::*;

   logic ack_q, src_q, trig_q, pll_en_q, soft_q, cal_start_q, cal_done_q;
   logic [31:0] rd_q, rd_d;
   logic [7:0] dll_ctrl_q;
   logic [3:0] decim_q, rst_cnt_q, gap_cnt_q;
   logic sync1_q, sync2_q, sync3_q;
   sw_state_t state_q;
   logic active_src_q, gate_q;
   logic wb_req, wr, dll_en, decim_en;
   logic [7:0] idx;
   logic [2:0] dll_ph;

   assign wb_req = CYC_IN & STB_IN & ~ack_q;
   assign wr = wb_req & WE_IN & SEL_IN[0];
   assign idx = ADR_IN[ADR_W-1:2];
   assign dll_en = dll_ctrl_q[DLL_EN_BIT];
   assign decim_en = decim_q[DEC_EN_BIT];
   assign dll_ph = dll_ctrl_q[PHDLY_LSB+:3];

   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (RST_IN);
   // ****************************************
   // Bus slave
   // ****************************************
   always_comb begin
      rd_d = 32'h0000_0000;
      case (idx)
         IDX_DLL_CTRL: rd_d[7:0] = dll_ctrl_q;
         IDX_CLK_SRC: rd_d[SRC_BIT] = src_q;
         IDX_DECIM_PH: rd_d[3:0] = decim_q;
         IDX_CALIB: rd_d[CAL_TRIG_BIT] = trig_q;
         IDX_PLL_OUT: rd_d[PLL_CLK_EN_BIT] = pll_en_q;
         IDX_STATUS: begin
            rd_d[STAT_CAL_BIT] = cal_done_q;
            rd_d[STAT_SRC_BIT] = active_src_q;
            rd_d[STAT_DLLRST_BIT] = DLL_RESET_OUT;
         end
         default: rd_d = 32'h0000_0000;
      endcase
   end

   // Unmapped addresses still answer, reading zero
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         ack_q <= 1'b0;
         rd_q <= 32'h0000_0000;
      end else begin
         ack_q <= wb_req;
         rd_q <= wb_req ? rd_d : 32'h0000_0000;
      end
   end

   assign ACK_OUT = ack_q;
   assign DAT_OUT = rd_q;

   wb_ack_a: assert property (wb_req |=> ACK_OUT ##1 !ACK_OUT)
      else $error("bus ack not one cycle after request");

   // ****************************************
   // Control registers
   // ****************************************
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         src_q <= CLK_SRC_RST[SRC_BIT];
         decim_q <= DECIM_PH_RST[3:0];
         pll_en_q <= PLL_OUT_RST[PLL_CLK_EN_BIT];
      end else if (wr) begin
         if (idx == IDX_CLK_SRC) src_q <= DAT_IN[SRC_BIT];
         if (idx == IDX_DECIM_PH) decim_q <= DAT_IN[3:0];
         if (idx == IDX_PLL_OUT) pll_en_q <= DAT_IN[PLL_CLK_EN_BIT];
      end
   end

   // auto clear after soft reset; a write of 1 wins
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         dll_ctrl_q <= DLL_CTRL_RST;
      end else if (wr && idx == IDX_DLL_CTRL) begin
         dll_ctrl_q <= {1'b0, DAT_IN[6:0]};
      end else if (rst_cnt_q == 4'h1) begin
         dll_ctrl_q[DLL_RST_BIT] <= 1'b0;
      end
   end

   // ****************************************
   // Soft reset and delay loop reset
   // ****************************************
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         soft_q <= 1'b0;
      end else begin
         soft_q <= wr && idx == IDX_SOFT_RESET && DAT_IN[SOFT_RST_BIT];
      end
   end

   // timed reset only while the loop is on
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         rst_cnt_q <= 4'h0;
      end else if (soft_q && dll_en) begin
         rst_cnt_q <= DLL_RST_CYC;
      end else if (rst_cnt_q != 4'h0) begin
         rst_cnt_q <= rst_cnt_q - 4'h1;
      end
   end

   // hold loop in reset while bit set
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         DLL_RESET_OUT <= 1'b1;
      end else begin
         DLL_RESET_OUT <= dll_ctrl_q[DLL_RST_BIT] | (rst_cnt_q != 4'h0);
      end
   end

   dll_hold_a: assert property (dll_ctrl_q[DLL_RST_BIT] |=> DLL_RESET_OUT)
      else $error("delay loop left reset while bit set");
   sequence auto_reset_s;
      ##2 DLL_RESET_OUT [*5];
   endsequence
   auto_rst_a: assert property (soft_q && dll_en |-> auto_reset_s)
      else $error("soft reset did not hold delay loop reset");
   auto_clr_a: assert property (
      rst_cnt_q == 4'h1 && !(wr && idx == IDX_DLL_CTRL) |=> !dll_ctrl_q[DLL_RST_BIT])
      else $error("reset bit not cleared after soft reset");

   // ****************************************
   // Synthesiser calibration
   // ****************************************
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         trig_q <= CALIB_RST[CAL_TRIG_BIT];
      end else if (wr && idx == IDX_CALIB) begin
         trig_q <= DAT_IN[CAL_TRIG_BIT];
      end
   end

   // start on toggle or soft reset
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         cal_start_q <= 1'b0;
      end else begin
         cal_start_q <= soft_q |
            (wr && idx == IDX_CALIB && DAT_IN[CAL_TRIG_BIT] != trig_q);
      end
   end

   assign CALIB_START_OUT = cal_start_q;

   // Done level comes from the analog side
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
      end else begin
         sync1_q <= CALIB_DONE_IN;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // completion flag; a new start wins
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         cal_done_q <= 1'b0;
      end else if (cal_start_q) begin
         cal_done_q <= 1'b0;
      end else if (sync2_q && !sync3_q) begin
         cal_done_q <= 1'b1;
      end
   end
   cal_start_a: assert property (
      wr && idx == IDX_CALIB && DAT_IN[CAL_TRIG_BIT] != trig_q
      |=> CALIB_START_OUT ##1 !cal_done_q)
      else $error("calibration not started by trigger toggle");

   // ****************************************
   // Glitch free source switch
   // ****************************************
   // gate off, swap, then gate on
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         state_q <= SW_RUN;
         gap_cnt_q <= 4'h0;
         active_src_q <= 1'b0;
         gate_q <= 1'b1;
      end else begin
         case (state_q)
            SW_RUN: begin
               if (src_q != active_src_q) begin
                  gate_q <= 1'b0;
                  gap_cnt_q <= SWITCH_GAP_CYC - 4'h1;
                  state_q <= SW_STOP;
               end
            end
            SW_STOP: begin
               if (gap_cnt_q == 4'h0) begin
                  active_src_q <= src_q;
                  gap_cnt_q <= SWITCH_GAP_CYC - 4'h1;
                  state_q <= SW_SWAP;
               end else begin
                  gap_cnt_q <= gap_cnt_q - 4'h1;
               end
            end
            SW_SWAP: begin
               if (gap_cnt_q == 4'h0) begin
                  gate_q <= 1'b1;
                  state_q <= SW_RUN;
               end else begin
                  gap_cnt_q <= gap_cnt_q - 4'h1;
               end
            end
            default: begin
               gate_q <= 1'b0;
               state_q <= SW_RUN;
            end
         endcase
      end
   end

   // ****************************************
   // Clock path outputs
   // ****************************************
   // default direct path, loops idle
   // loop path only with source 0
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         CORE_SRC_PLL_OUT <= 1'b0;
         CORE_CLK_GATE_OUT <= 1'b1;
         DLL_ENABLE_OUT <= 1'b0;
      end else begin
         CORE_SRC_PLL_OUT <= active_src_q;
         CORE_CLK_GATE_OUT <= gate_q;
         DLL_ENABLE_OUT <= dll_en & ~active_src_q;
      end
   end

   // never on the synthesiser clock
   // Trim adds jitter, so it stays off unless asked for
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         DUTY_CORR_OUT <= 1'b0;
      end else begin
         DUTY_CORR_OUT <= dll_en & dll_ctrl_q[DUTY_BIT] & ~active_src_q;
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         PLL_CLK_CORE_OUT <= 1'b0;
      end else begin
         PLL_CLK_CORE_OUT <= pll_en_q & active_src_q & gate_q;
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         OUT_CLK_DLL_OUT <= 1'b0;
         OUT_CLK_DECIM_OUT <= 1'b0;
         OUT_PHASE_OUT <= 3'h0;
      end else begin
         OUT_CLK_DLL_OUT <= dll_en & dll_ctrl_q[DLL_OUTPUT_DATA_CLOCK_BIT] & ~active_src_q & ~decim_en;
         OUT_CLK_DECIM_OUT <= decim_en;
         if (decim_en) begin
            OUT_PHASE_OUT <= decim_q[DEC_PH_LSB+:3];
         end else if (active_src_q || (dll_en && dll_ctrl_q[DLL_OUTPUT_DATA_CLOCK_BIT])) begin
            OUT_PHASE_OUT <= dll_ph;
         end else begin
            OUT_PHASE_OUT <= 3'h0;
         end
      end
   end
   default_dir_a: assert property (
      $past(RST_IN) |-> !CORE_SRC_PLL_OUT && !DLL_ENABLE_OUT && !PLL_CLK_CORE_OUT)
      else $error("clock paths not at default after reset");
   pll_path_a: assert property (CORE_SRC_PLL_OUT |-> !DLL_ENABLE_OUT && !DUTY_CORR_OUT)
      else $error("loop active on synthesiser path");
   dll_path_a: assert property (!active_src_q && dll_en |=> DLL_ENABLE_OUT)
      else $error("loop path not enabled on source 0");
   duty_gate_a: assert property (DUTY_CORR_OUT |-> $past(dll_en && !active_src_q))
      else $error("duty correction without delay loop");
   dec_phase_a: assert property (
      decim_en |=> OUT_CLK_DECIM_OUT && !OUT_CLK_DLL_OUT
      && OUT_PHASE_OUT == $past(decim_q[DEC_PH_LSB+:3]))
      else $error("decimation phase not applied");
   dll_output_data_clock_a: assert property (
      dll_en && dll_ctrl_q[DLL_OUTPUT_DATA_CLOCK_BIT] && !active_src_q && !decim_en
      |=> OUT_CLK_DLL_OUT && OUT_PHASE_OUT == $past(dll_ph))
      else $error("loop output phase not applied");
   pll_gate_a: assert property (
      PLL_CLK_CORE_OUT |-> $past(pll_en_q) && CORE_SRC_PLL_OUT && CORE_CLK_GATE_OUT)
      else $error("synthesiser clock reached core while disabled");
   sequence gate_quiet_s;
      !CORE_CLK_GATE_OUT [*3];
   endsequence
   // no gating edge near a swap
   switch_safe_a: assert property (
      $changed(CORE_SRC_PLL_OUT) |-> $past(!CORE_CLK_GATE_OUT) ##0 gate_quiet_s)
      else $error("core clock gate open during source swap");
endmodule // adc_sample_clock_select

// ===== tb/calib_source_model.sv
// Purpose: Analog calibration engine seen from the clock select block
// Assumes: Start is a one-cycle pulse, done is a level back to the block
// Notes: Delay input lets the bench answer promptly or slowly
module calib_source_model (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic start_in,
   input wire logic [3:0] delay_in,
   output logic done_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_q;
   // ****************************************
   // Calibration run
   // ****************************************
   // start drops done, done after delay
   always @(posedge clk_in) begin
      if (rst_in) begin
         done_out <= 1'b0;
         cnt_q <= 4'h0;
      end else if (start_in) begin
         done_out <= 1'b0;
         cnt_q <= delay_in;
      end else if (cnt_q == 4'h1) begin
         done_out <= 1'b1;
         cnt_q <= 4'h0;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end
   end
endmodule // calib_source_model

// ===== tb/adc_sample_clock_select_test.sv
// Purpose: Self-checking bench of the sample clock select block
// Assumes: Wishbone answers one cycle after a request is taken
// Notes: Outputs lag register writes, so checks wait a settle time
module adc_sample_clock_select_test;
   timeunit 1ns;
   timeprecision 1ns;
   import clk_sel_pkg::*;
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [3:0] sel = 4'h0, dly = 4'h3;
   logic [ADR_W-1:0] adr = '0;
   logic [31:0] dat = 32'h0, dat_o;
   logic ack, done, src_o, gate, dll_en, dll_rst, duty, oc_dll, oc_dec, pll_core, cal_start;
   logic [2:0] phase;
   logic src_prev = 1'b0;
   logic [7:0] rd, c, d;
   logic s, p;
   int fail_count = 0, checks = 0, cycles = 0, n_rst, n_cal;
   always #50 clk = ~clk;
   adc_sample_clock_select i_adc_sample_clock_select (.REF_CLK_IN(clk), .RST_IN(rst),
      .CYC_IN(cyc), .STB_IN(stb), .WE_IN(we), .SEL_IN(sel), .ADR_IN(adr), .DAT_IN(dat),
      .DAT_OUT(dat_o), .ACK_OUT(ack), .CALIB_DONE_IN(done), .CORE_SRC_PLL_OUT(src_o),
      .CORE_CLK_GATE_OUT(gate), .DLL_ENABLE_OUT(dll_en), .DLL_RESET_OUT(dll_rst),
      .DUTY_CORR_OUT(duty), .OUT_CLK_DLL_OUT(oc_dll), .OUT_CLK_DECIM_OUT(oc_dec),
      .OUT_PHASE_OUT(phase), .PLL_CLK_CORE_OUT(pll_core), .CALIB_START_OUT(cal_start));
   calib_source_model i_calib_source_model (.clk_in(clk), .rst_in(rst), .start_in(cal_start),
      .delay_in(dly), .done_out(done));
   // ****************************************
   // Helpers
   // ****************************************
   task automatic summarize();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
      output logic [7:0] r);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hF;
      adr <= {idx, 2'b00};
      dat <= {24'h0, wd};
      do @(posedge clk); while (ack !== 1'b1);
      r = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic watch(input int n);
      n_rst = 0;
      n_cal = 0;
      repeat (n) begin
         @(posedge clk);
         n_rst += int'(dll_rst === 1'b1);
         n_cal += int'(cal_start === 1'b1);
      end
   endtask
   // Phase source follows decimation first, then the loop field
   function automatic logic [8:0] exp_out(logic [7:0] cc, logic ss, logic [7:0] dd, logic pp);
      logic le;
      le = cc[0] & ~ss;
      exp_out = {le, le & cc[1], le & cc[2] & ~dd[3], dd[3],
         dd[3] ? dd[2:0] : ((ss | (cc[0] & cc[2])) ? cc[5:3] : 3'h0), pp & ss, ss};
   endfunction
   // gate closed whenever the source swaps
   always @(posedge clk) begin
      if (!rst && src_o !== src_prev) chk("gate at swap", gate, 0);
      src_prev <= src_o;
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         summarize();
      end
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      void'($urandom(32'hD9427FB4));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("reset outs", {dll_en, duty, oc_dll, oc_dec, phase, pll_core, src_o, gate, dll_rst},
         11'h3);
      wb(0, IDX_DLL_CTRL, 8'h00, rd);
      chk("ctrl reset", rd, DLL_CTRL_RST);
      wb(0, IDX_CLK_SRC, 8'h00, rd);
      chk("src reset", rd, CLK_SRC_RST);
      wb(0, IDX_PLL_OUT, 8'h00, rd);
      chk("synth en reset", rd, PLL_OUT_RST);
      wb(1, IDX_DLL_CTRL, 8'h00, rd);
      repeat (3) @(posedge clk);
      chk("loop reset released", dll_rst, 0);
      // Random settings, bit 6 kept clear so the loop stays out of reset
      for (int i = 0; i < 12; i++) begin
         c = 8'($urandom) & 8'hBF;
         d = 8'($urandom) & 8'h0F;
         s = 1'($urandom);
         p = 1'($urandom);
         dly <= 4'($urandom_range(9, 2));
         wb(1, IDX_DLL_CTRL, c, rd);
         wb(1, IDX_DECIM_PH, d, rd);
         wb(1, IDX_PLL_OUT, {7'h0, p}, rd);
         wb(1, IDX_CLK_SRC, {7'h0, s}, rd);
         repeat (14) @(posedge clk);
         chk("clock outs", {dll_en, duty, oc_dll, oc_dec, phase, pll_core, src_o},
            exp_out(c, s, d, p));
         chk("gate open", gate, 1);
         wb(0, IDX_DLL_CTRL, 8'h00, rd);
         chk("ctrl readback", rd, c & 8'h3F);
         wb(0, IDX_STATUS, 8'h00, rd);
         chk("active source", rd[STAT_SRC_BIT], s);
      end
      // Soft reset with the loop on
      wb(1, IDX_CLK_SRC, 8'h00, rd);
      repeat (14) @(posedge clk);
      wb(1, IDX_DLL_CTRL, 8'h01, rd);
      dly <= 4'hC;
      wb(1, IDX_SOFT_RESET, 8'h01, rd);
      watch(12);
      chk("loop reset cycles", n_rst, DLL_RST_CYC);
      chk("soft calib start", n_cal, 1);
      wb(0, IDX_DLL_CTRL, 8'h00, rd);
      chk("reset bit cleared", rd, 8'h01);
      wb(1, IDX_DLL_CTRL, 8'h41, rd);
      wb(1, IDX_SOFT_RESET, 8'h01, rd);
      watch(12);
      wb(0, IDX_DLL_CTRL, 8'h00, rd);
      chk("set bit auto cleared", rd, 8'h01);
      chk("loop out of reset", dll_rst, 0);
      // Calibration toggle, slow answer
      repeat (20) @(posedge clk);
      wb(1, IDX_CALIB, 8'h01, rd);
      wb(0, IDX_STATUS, 8'h00, rd);
      chk("done cleared", rd[2:0], 3'h0);
      repeat (20) @(posedge clk);
      wb(0, IDX_STATUS, 8'h00, rd);
      chk("done seen", rd[2:0], 3'h1);
      wb(1, IDX_CALIB, 8'h01, rd);
      watch(6);
      chk("same trigger idle", n_cal, 0);
      // Unmapped place and read-only status
      wb(1, 8'h20, 8'hA5, rd);
      wb(0, 8'h20, 8'h00, rd);
      chk("unmapped read", rd, 8'h00);
      wb(1, IDX_STATUS, 8'hFF, rd);
      wb(0, IDX_STATUS, 8'h00, rd);
      chk("status read only", rd[2:0], 3'h1);
      summarize();
   end
endmodule // adc_sample_clock_select_test
